// file: hdl/awic_defs.vh
// Register map, field positions and reset values of the area wait/idle control block.
`ifndef AWIC_DEFS_VH
`define AWIC_DEFS_VH

// ----------------------------------------------------------------
// Register word indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define AWIC_IDX_IDLE     2'h0
`define AWIC_IDX_WAIT     2'h1
`define AWIC_IDX_STAT     2'h2

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define AWIC_IDLE_RESET   16'h3FF3
`define AWIC_IDLE_MASK    16'h3FF3
`define AWIC_WAIT_RESET   16'hFFE0
`define AWIC_WAIT_MASK    16'hFFE0

// ----------------------------------------------------------------
// Idle field least significant bits (two bits each)
// ----------------------------------------------------------------
`define AWIC_A6_IDLE_LSB  12
`define AWIC_A5_IDLE_LSB  10
`define AWIC_A4_IDLE_LSB  8
`define AWIC_A3_IDLE_LSB  6
`define AWIC_A2_IDLE_LSB  4
`define AWIC_A0_IDLE_LSB  0

// ----------------------------------------------------------------
// Wait field least significant bits
// ----------------------------------------------------------------
`define AWIC_A6_WAIT_LSB  13
`define AWIC_A5_WAIT_LSB  10
`define AWIC_A4_WAIT_LSB  7
`define AWIC_A3_WAIT_LSB  5

// ----------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------
`define AWIC_RESP_OKAY    2'h0
`define AWIC_RESP_SLVERR  2'h2

`endif

// file: hdl/awic_decode.v
// Per-area decoder of idle, wait, burst pitch and wait-pin enables.
`timescale 1ns/1ps
`include "awic_defs.vh"

module awic_decode (
   // Register contents
   input  wire [15:0] idle_reg,
   input  wire [15:0] wait_reg,
   input  wire        area3_sdram,
   // Area to decode
   input  wire [2:0]  area,
   // Decoded timing
   output reg  [1:0]  idle_cycles,
   output reg  [3:0]  first_waits,
   output reg  [3:0]  burst_pitch,
   output reg         first_wait_en,
   output reg         burst_wait_en
);

   reg [1:0] idle_code;
   reg [2:0] wcode;

   // ----------------------------------------------------------------
   // Field selection and decode
   // ----------------------------------------------------------------
   // Areas without a field fall back to one idle cycle and no waits.
   always @* begin
      idle_code     = 2'h0;
      wcode         = 3'h0;
      first_waits   = 4'h0;
      first_wait_en = 1'b0;
      case (area)
         3'h0: begin
            idle_code = idle_reg[`AWIC_A0_IDLE_LSB+1:`AWIC_A0_IDLE_LSB];
         end
         3'h2: begin
            idle_code = idle_reg[`AWIC_A2_IDLE_LSB+1:`AWIC_A2_IDLE_LSB];
         end
         3'h3: begin
            idle_code = idle_reg[`AWIC_A3_IDLE_LSB+1:`AWIC_A3_IDLE_LSB];
            wcode = {1'b0, wait_reg[`AWIC_A3_WAIT_LSB+1:`AWIC_A3_WAIT_LSB]};
            if (area3_sdram) begin
               first_waits = (wcode == 3'h0) ? 4'h1 : {1'b0, wcode};
            end else begin
               first_waits   = {1'b0, wcode};
               first_wait_en = (wcode != 3'h0);
            end
         end
         3'h4: begin
            idle_code = idle_reg[`AWIC_A4_IDLE_LSB+1:`AWIC_A4_IDLE_LSB];
            wcode = wait_reg[`AWIC_A4_WAIT_LSB+2:`AWIC_A4_WAIT_LSB];
         end
         3'h5: begin
            idle_code = idle_reg[`AWIC_A5_IDLE_LSB+1:`AWIC_A5_IDLE_LSB];
            // area 5 code, clamped at four
            wcode = wait_reg[`AWIC_A5_WAIT_LSB+2:`AWIC_A5_WAIT_LSB];
            if (wcode > 3'h4)
               wcode = 3'h4;
         end
         3'h6: begin
            idle_code = idle_reg[`AWIC_A6_IDLE_LSB+1:`AWIC_A6_IDLE_LSB];
            wcode = wait_reg[`AWIC_A6_WAIT_LSB+2:`AWIC_A6_WAIT_LSB];
         end
         default: begin
            idle_code = 2'h0;
         end
      endcase
      // first-access waits grow by two above code 100
      if (area == 3'h4 || area == 3'h5 || area == 3'h6) begin
         first_waits   = (wcode[2]) ? ({wcode, 1'b0} - 4'h4) : {1'b0, wcode};
         first_wait_en = (wcode != 3'h0);
      end
      // idle code 00 and 01 both mean one cycle
      idle_cycles = (idle_code == 2'h0) ? 2'h1 : idle_code;
      // area 5 and 6 burst pitch has a floor of two, codes 010 and 011 add one
      if (area == 3'h5 || area == 3'h6) begin
         burst_wait_en = 1'b1;
         if (wcode < 3'h2)
            burst_pitch = 4'h2;
         else if (wcode < 3'h4)
            burst_pitch = {1'b0, wcode} + 4'h1;
         else
            burst_pitch = first_waits;
      end else begin
         burst_wait_en = first_wait_en;
         burst_pitch   = first_waits + 4'h1;
      end
   end

endmodule // awic_decode

// file: hdl/awic_top.v
// Area wait/idle control: AXI4-Lite registers and external access timing.
// Operation
// - Idle bits 7:6 give area 3 idles on leaving it or read-to-write.
// - Idle bits 5:4 give area 2 idles on leaving it or read-to-write.
// - Idle bits 1:0 give area 0 idles on leaving it or read-to-write.
// - Idle code 00 or 01 is one cycle, 10 two, 11 three.
// - Idle bits 3:2 read zero; software writes zero there.
// - Wait register is 16 bits, sets waits and burst pitch per area.
// - Wait bits 15:13 set area 6 first waits and burst pitch.
// - Wait bits 12:10 set area 5 first waits and burst pitch.
// - Wait bits 9:7 set area 4 wait states.
// - Area 3 ordinary memory: code gives 0-3 waits, pin ignored at 00.
// - Area 3 SDRAM: code gives CAS latency 1, 1, 2, 3.
// - Idle register resets to 3FF3 on power-on reset only.
// - Area 6 codes give waits 0-10 and burst pitch 2-10.
// - Area 5 codes 000-100 give waits 0-4 and burst pitch 2-4.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "awic_defs.vh"

module awic_top #(
   parameter ADDR_W = 12
) (
   // Clock, power-on reset and clock enable
   input  wire              aclk,
   input  wire              aresetn,
   input  wire              ce,
   // AXI4-Lite write address and data
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]        s_axi_awprot,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   // AXI4-Lite write response
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   output reg  [1:0]        s_axi_bresp,
   // AXI4-Lite read
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]        s_axi_arprot,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   // Access request from the bus state logic
   input  wire              acc_valid,
   output reg               acc_ready,
   input  wire [2:0]        acc_area,
   input  wire              acc_write,
   input  wire [3:0]        acc_beats,
   // Memory type strap and external wait pin
   input  wire              area3_sdram,
   input  wire              ext_wait_n,
   // Access timing outputs
   output reg               idle_gap,
   output reg               data_cycle,
   output reg               beat_done,
   output reg               acc_done,
   output reg  [1:0]        cas_latency
);

   // ----------------------------------------------------------------
   // State encoding
   // ----------------------------------------------------------------
   localparam [3:0] S_IDLE  = 4'b0001;
   localparam [3:0] S_GAP   = 4'b0010;
   localparam [3:0] S_FIRST = 4'b0100;
   localparam [3:0] S_BURST = 4'b1000;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg  [15:0]       intercycle_idle_control;
   reg  [15:0]       area_wait_control;
   reg  [ADDR_W-1:0] wr_addr;
   reg  [31:0]       wr_data;
   reg  [3:0]        wr_strb;
   reg  [3:0]        state;
   reg  [3:0]        cnt;
   reg  [3:0]        beats_left;
   reg  [2:0]        cur_area;
   reg  [2:0]        last_area;
   reg               last_write;
   reg               has_prev;
   reg               cur_write;
   reg               wait_meta;
   reg               wait_sync;
   reg  [31:0]       read_word;
   reg               read_hit;
   reg               write_hit;
   reg  [15:0]       next_idle;
   reg  [15:0]       next_wait;
   reg               need_gap;
   wire              wr_go;
   wire [1:0]        prev_idle;
   wire [3:0]        new_waits;
   wire              new_wait_en;
   wire [3:0]        run_waits;
   wire [3:0]        run_pitch;
   wire              run_first_en;
   wire              run_burst_en;
   wire [31:0]       stat_word;

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------
   // Previous area gives the idle count, requested area the first waits.
   awic_decode u_prev (
      .idle_reg      (intercycle_idle_control),
      .wait_reg      (area_wait_control),
      .area3_sdram   (area3_sdram),
      .area          (last_area),
      .idle_cycles   (prev_idle),
      .first_waits   (),
      .burst_pitch   (),
      .first_wait_en (),
      .burst_wait_en ()
   );

   awic_decode u_new (
      .idle_reg      (intercycle_idle_control),
      .wait_reg      (area_wait_control),
      .area3_sdram   (area3_sdram),
      .area          (acc_area),
      .idle_cycles   (),
      .first_waits   (new_waits),
      .burst_pitch   (),
      .first_wait_en (new_wait_en),
      .burst_wait_en ()
   );

   // Running access; registers may change under it, which is tolerated.
   awic_decode u_run (
      .idle_reg      (intercycle_idle_control),
      .wait_reg      (area_wait_control),
      .area3_sdram   (area3_sdram),
      .area          (cur_area),
      .idle_cycles   (),
      .first_waits   (run_waits),
      .burst_pitch   (run_pitch),
      .first_wait_en (run_first_en),
      .burst_wait_en (run_burst_en)
   );

   // ----------------------------------------------------------------
   // Register write path
   // ----------------------------------------------------------------
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   // Merge byte lanes into both registers; unused bits stay zero.
   always @* begin
      next_idle = intercycle_idle_control;
      next_wait = area_wait_control;
      if (wr_strb[0]) begin
         next_idle[7:0] = wr_data[7:0];
         next_wait[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
         next_idle[15:8] = wr_data[15:8];
         next_wait[15:8] = wr_data[15:8];
      end
      next_idle = next_idle & `AWIC_IDLE_MASK;
      next_wait = next_wait & `AWIC_WAIT_MASK;
      write_hit = (wr_addr[ADDR_W-1:4] == 0) &&
                  (wr_addr[3:2] == `AWIC_IDX_IDLE || wr_addr[3:2] == `AWIC_IDX_WAIT);
   end

   // Address and data are caught in either order; the answer needs both.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `AWIC_RESP_OKAY;
         wr_addr       <= {ADDR_W{1'b0}};
         wr_data       <= 32'h00000000;
         wr_strb       <= 4'h0;
         intercycle_idle_control <= `AWIC_IDLE_RESET;
         area_wait_control       <= `AWIC_WAIT_RESET;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= write_hit ? `AWIC_RESP_OKAY : `AWIC_RESP_SLVERR;
            if (write_hit && wr_addr[3:2] == `AWIC_IDX_IDLE)
               intercycle_idle_control <= next_idle;
            if (write_hit && wr_addr[3:2] == `AWIC_IDX_WAIT)
               area_wait_control <= next_wait;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register read path
   // ----------------------------------------------------------------
   assign stat_word = {21'h000000, has_prev, cas_latency, last_write,
                       last_area, state};

   // Status is read-only; the two control words read back as stored.
   always @* begin
      read_word = 32'h00000000;
      read_hit  = (s_axi_araddr[ADDR_W-1:4] == 0);
      case (s_axi_araddr[3:2])
         `AWIC_IDX_IDLE: begin
            read_word = {16'h0000, intercycle_idle_control & `AWIC_IDLE_MASK};
         end
         `AWIC_IDX_WAIT: begin
            read_word = {16'h0000, area_wait_control};
         end
         `AWIC_IDX_STAT: begin
            read_word = stat_word;
         end
         default: begin
            read_hit = 1'b0;
         end
      endcase
   end

   // One read at a time; arready falls while the answer stands.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `AWIC_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= read_hit ? read_word : 32'h00000000;
            s_axi_rresp   <= read_hit ? `AWIC_RESP_OKAY : `AWIC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Wait pin synchroniser
   // ----------------------------------------------------------------
   // The pin is asynchronous to aclk, so two flops come before any use.
   always @(posedge aclk) begin
      if (!aresetn) begin
         wait_meta <= 1'b0;
         wait_sync <= 1'b0;
      end else if (ce) begin
         wait_meta <= !ext_wait_n;
         wait_sync <= wait_meta;
      end
   end

   // ----------------------------------------------------------------
   // Gap detection
   // ----------------------------------------------------------------
   // A gap follows leaving an area or a read turning into a write there.
   always @* begin
      need_gap = has_prev &&
                 ((acc_area != last_area) || (!last_write && acc_write));
   end

   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         state       <= S_IDLE;
         cnt         <= 4'h0;
         beats_left  <= 4'h0;
         cur_area    <= 3'h0;
         cur_write   <= 1'b0;
         last_area   <= 3'h0;
         last_write  <= 1'b0;
         has_prev    <= 1'b0;
         acc_ready   <= 1'b1;
         idle_gap    <= 1'b0;
         data_cycle  <= 1'b0;
         beat_done   <= 1'b0;
         acc_done    <= 1'b0;
         cas_latency <= 2'h3;
      end else if (ce) begin
         beat_done <= 1'b0;
         acc_done  <= 1'b0;
         // SDRAM CAS latency shown on its own output
         cas_latency <= (area_wait_control[`AWIC_A3_WAIT_LSB+1:`AWIC_A3_WAIT_LSB] == 2'h0)
                        ? 2'h1 : area_wait_control[`AWIC_A3_WAIT_LSB+1:`AWIC_A3_WAIT_LSB];
         case (state)
            S_IDLE: begin
               if (acc_valid && acc_ready) begin
                  acc_ready  <= 1'b0;
                  cur_area   <= acc_area;
                  cur_write  <= acc_write;
                  beats_left <= (acc_beats == 4'h0) ? 4'h0 : acc_beats - 4'h1;
                  if (need_gap) begin
                     // idles of the area being left, decoded
                     state    <= S_GAP;
                     cnt      <= {2'h0, prev_idle} - 4'h1;
                     idle_gap <= 1'b1;
                  end else begin
                     state      <= S_FIRST;
                     cnt        <= new_waits;
                     data_cycle <= 1'b1;
                  end
               end
            end
            S_GAP: begin
               if (cnt == 4'h0) begin
                  state      <= S_FIRST;
                  cnt        <= run_waits;
                  idle_gap   <= 1'b0;
                  data_cycle <= 1'b1;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            S_FIRST: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               // enabled wait pin holds the first access
               end else if (!(run_first_en && wait_sync)) begin
                  beat_done <= 1'b1;
                  if (beats_left == 4'h0) begin
                     state      <= S_IDLE;
                     data_cycle <= 1'b0;
                     acc_done   <= 1'b1;
                     acc_ready  <= 1'b1;
                     last_area  <= cur_area;
                     last_write <= cur_write;
                     has_prev   <= 1'b1;
                  end else begin
                     // burst beats at the area pitch
                     state      <= S_BURST;
                     cnt        <= run_pitch - 4'h1;
                     beats_left <= beats_left - 4'h1;
                  end
               end
            end
            S_BURST: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               // enabled wait pin holds each burst beat
               end else if (!(run_burst_en && wait_sync)) begin
                  beat_done <= 1'b1;
                  if (beats_left == 4'h0) begin
                     state      <= S_IDLE;
                     data_cycle <= 1'b0;
                     acc_done   <= 1'b1;
                     acc_ready  <= 1'b1;
                     last_area  <= cur_area;
                     last_write <= cur_write;
                     has_prev   <= 1'b1;
                  end else begin
                     cnt        <= run_pitch - 4'h1;
                     beats_left <= beats_left - 4'h1;
                  end
               end
            end
            default: begin
               state      <= S_IDLE;
               acc_ready  <= 1'b1;
               idle_gap   <= 1'b0;
               data_cycle <= 1'b0;
            end
         endcase
      end
   end

endmodule // awic_top

// file: testbench/awic_monitor.sv
// Port checker of the area wait/idle control block.
`timescale 1ns/1ps
module awic_monitor #(parameter ADDR_W = 12) (
   // Clock and reset
   input wire              aclk,
   input wire              aresetn,
   // Register bus
   input wire              s_axi_bvalid,
   input wire              s_axi_bready,
   input wire [1:0]        s_axi_bresp,
   input wire              s_axi_arvalid,
   input wire              s_axi_arready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire              s_axi_rvalid,
   input wire              s_axi_rready,
   input wire [31:0]       s_axi_rdata,
   // Access timing
   input wire              idle_gap,
   input wire              data_cycle,
   input wire              beat_done,
   input wire              ext_wait_n,
   input wire [1:0]        cas_latency
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg [3:0] idle_run;
   reg [3:0] stall_run;
   // Run lengths; the stall count restarts while the pin holds the access.
   always @(posedge aclk) begin
      idle_run  <= (!aresetn || !idle_gap) ? 4'h0 : idle_run + 4'h1;
      stall_run <= (!aresetn || !data_cycle || beat_done || !ext_wait_n) ?
                   4'h0 : stall_run + 4'h1;
   end
   a_idle_run_max: assert property (idle_gap |-> idle_run < 4'h3)
      else $error("idle gap longer than three cycles");
   a_idle_apart: assert property (!(idle_gap && data_cycle))
      else $error("idle and data cycle together");
   a_stall_bound: assert property (data_cycle |-> stall_run < 4'hE)
      else $error("beat longer than the slowest code");
   a_cas_legal: assert property (cas_latency != 2'h0)
      else $error("cas latency zero");
   a_reset_slow: assert property ($rose(aresetn) |-> cas_latency == 2'h3)
      else $error("cas latency not slowest after reset");
   a_rsvd_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == '0
      |=> s_axi_rdata[3:2] == 2'h0 && s_axi_rdata[31:16] == 16'h0)
      else $error("reserved idle bits read nonzero");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   cover property (idle_gap ##1 !idle_gap);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cover property (data_cycle && !ext_wait_n);
endmodule // awic_monitor

// file: testbench/awic_mem_model.sv
// Model of a slow external memory that may hold the wait pin.
`timescale 1ns/1ps
module awic_mem_model (
   // Clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // Access timing and commanded hold length
   input  wire       data_cycle,
   input  wire [3:0] stretch,
   // Wait pin, pulled up when not held
   output wire       ext_wait_n
);
   reg [3:0] left;
   reg       data_q;
   // hold wait pin
   // The pin is held from the second data cycle of an access, as a slow device would.
   always @(posedge aclk) begin
      data_q <= data_cycle;
      if (!aresetn) left <= 4'h0;
      else if (left != 4'h0) left <= left - 4'h1;
      else if (data_cycle && !data_q) left <= stretch;
   end
   assign ext_wait_n = (left == 4'h0);
endmodule // awic_mem_model

// file: testbench/test_awic_top.sv
// Self-checking bench of the area wait/idle control block.
`timescale 1ns/1ps
module test_awic_top;
   reg         aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   reg         arvalid = 1'h0, rready = 1'h0, acc_valid = 1'h0, acc_write = 1'h0;
   reg         area3_sdram = 1'h0;
   reg  [11:0] awaddr = 12'h0, araddr = 12'h0;
   reg  [31:0] wdata = 32'h0, rd, d;
   reg  [2:0]  acc_area = 3'h0;
   reg  [3:0]  acc_beats = 4'h1, stretch = 4'h0;
   reg  [1:0]  resp;
   wire        awready, wready, bvalid, arready, rvalid, acc_ready, ext_wait_n;
   wire        idle_gap, data_cycle, beat_done, acc_done;
   wire [1:0]  bresp, rresp, cas_latency;
   wire [31:0] rdata;
   integer     errors = 0, checks = 0, cycles = 0, c, m, cyc, gap;
   int         w6 [8] = '{0, 1, 2, 3, 4, 6, 8, 10};
   int         p6 [8] = '{2, 2, 3, 4, 4, 6, 8, 10};
   int         g  [4] = '{1, 1, 2, 3};
   awic_top u_dut (
      .aclk(aclk), .aresetn(aresetn), .ce(1'h1),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .acc_valid(acc_valid), .acc_ready(acc_ready),
      .acc_area(acc_area), .acc_write(acc_write), .acc_beats(acc_beats),
      .area3_sdram(area3_sdram), .ext_wait_n(ext_wait_n), .idle_gap(idle_gap),
      .data_cycle(data_cycle), .beat_done(beat_done), .acc_done(acc_done),
      .cas_latency(cas_latency));
   awic_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .data_cycle(data_cycle),
      .stretch(stretch), .ext_wait_n(ext_wait_n));
   // 200 MHz clock.
   initial forever #2.5 aclk = ~aclk;
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks = checks + 1;
      if (s !== e) begin
         errors = errors + 1;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask
   // Response ready comes late on purpose, so the slave must hold its answer.
   task wr(input [11:0] a, input [31:0] v);
      @(posedge aclk);
      awvalid <= 1'h1; wvalid <= 1'h1; awaddr <= a; wdata <= v;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      repeat (2) @(posedge aclk);
      bready <= 1'h1;
      do @(posedge aclk); while (!bvalid);
      resp = bresp;
      bready <= 1'h0;
   endtask
   task rdr(input [11:0] a);
      @(posedge aclk);
      arvalid <= 1'h1; araddr <= a;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      @(posedge aclk);
      rready <= 1'h1;
      do @(posedge aclk); while (!rvalid);
      rd = rdata; resp = rresp;
      rready <= 1'h0;
   endtask
   // Counts idle cycles and the remaining cycles of one access.
   task acc(input [2:0] ar, input w, input [3:0] b);
      @(posedge aclk);
      acc_valid <= 1'h1; acc_area <= ar; acc_write <= w; acc_beats <= b;
      do @(posedge aclk); while (!acc_ready);
      acc_valid <= 1'h0;
      cyc = 0; gap = 0;
      do begin
         #1;
         if (data_cycle === 1'h1) cyc = cyc + 1;
         if (idle_gap === 1'h1) gap = gap + 1;
         if (acc_done !== 1'h1) @(posedge aclk);
      end while (acc_done !== 1'h1);
   endtask
   task wrap_up;
      if (errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // A hang counts as a mismatch.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rdr(12'h0); chk("idle reset", 32'h3FF3, rd);
      rdr(12'h4); chk("wait reset", 32'hFFE0, rd);
      wr(12'h0, 32'hFFFF); rdr(12'h0); chk("idle mask", 32'h3FF3, rd);
      wr(12'h8, 32'h0); chk("status write", 2'h2, resp);
      rdr(12'hC); chk("unmapped read", 2'h2, resp);
      for (c = 0; c < 8; c++) begin
         m = c > 4 ? 4 : c;
         d = (c << 13) | (m << 10) | (c << 7) | ((c & 3) << 5);
         wr(12'h4, d); rdr(12'h4); chk("wait reg", d, rd);
         acc(3'h6, 1'h0, 4'h2); chk("area6 time", 1 + w6[c] + p6[c], cyc);
         acc(3'h5, 1'h0, 4'h2); chk("area5 time", 1 + w6[m] + p6[m], cyc);
         acc(3'h4, 1'h0, 4'h1); chk("area4 time", 1 + w6[c], cyc);
         acc(3'h3, 1'h0, 4'h1); chk("area3 time", 1 + (c & 3), cyc);
      end
      for (c = 0; c < 4; c++) begin
         wr(12'h4, c << 5);
         area3_sdram <= 1'h1;
         acc(3'h3, 1'h0, 4'h1); chk("sdram time", 1 + g[c], cyc);
         chk("cas latency", g[c], cas_latency);
      end
      for (c = 0; c < 4; c++) begin
         wr(12'h0, (c << 6) | (c << 4) | c);
         area3_sdram <= 1'h0;
         acc(3'h3, 1'h0, 4'h1);
         acc(3'h0, 1'h0, 4'h1); chk("area3 idles", g[c], gap);
         acc(3'h2, 1'h0, 4'h1); chk("area0 idles", g[c], gap);
         acc(3'h2, 1'h1, 4'h1); chk("area2 idles", g[c], gap);
      end
      wr(12'h4, 32'h0);
      stretch <= 4'h6;
      acc(3'h6, 1'h0, 4'h1); chk("pin ignored", 1, cyc);
      wr(12'h4, 32'h6000);
      acc(3'h6, 1'h0, 4'h1); chk("pin stretch", 1, cyc > 4);
      wrap_up;
   end
endmodule // test_awic_top
bind awic_top awic_monitor #(.ADDR_W(ADDR_W)) u_mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .idle_gap(idle_gap),
   .data_cycle(data_cycle), .beat_done(beat_done), .ext_wait_n(ext_wait_n),
   .cas_latency(cas_latency));
